// ### hdl/ggt_pkg.sv
/*
 * constants, field layouts and carrier types for the gain, link format
 * and line threshold register bank.
 * assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
 */
package ggt_pkg;
	// ****************************************
	// register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [5:0] IDX_RX_FINE_GAIN   = 6'h29;
	localparam logic [5:0] IDX_GCI_FORMAT     = 6'h2A;
	localparam logic [5:0] IDX_THR_VALUE      = 6'h2B;
	localparam logic [5:0] IDX_THR_IRQ_CTRL   = 6'h2C;
	localparam logic [5:0] IDX_IRQ_CONTROL    = 6'h30;
	localparam logic [5:0] IDX_IRQ_STATUS     = 6'h31;
	localparam logic [5:0] IDX_IRQ_MASK       = 6'h32;
	// ****************************************
	// field positions
	// ****************************************
	localparam int GAIN_DIR_BIT  = 4;
	localparam int FMT_LSB       = 2;
	localparam int B2_EN_BIT     = 1;
	localparam int B1_EN_BIT     = 0;
	localparam int THR_FLAG_BIT  = 3;
	localparam int THR_SEL_BIT   = 2;
	localparam int THR_MASK_BIT  = 1;
	localparam int THR_POL_BIT   = 0;
	localparam int GLOBAL_IRQ_ENABLE_BIT      = 0;
	localparam int SLOT_SEL_BIT  = 1;
	localparam int EV_TX_BIT     = 0;
	localparam int EV_RX_BIT     = 1;
	localparam int EV_SAT_BIT    = 2;
	// ****************************************
	// reset values and codes
	// ****************************************
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [1:0] FMT_ALAW     = 2'h0;
	localparam logic [1:0] FMT_MULAW    = 2'h1;
	localparam logic [1:0] FMT_LIN8     = 2'h2;
	localparam logic [1:0] FMT_LIN16    = 2'h3;
	// ****************************************
	// companding and gain constants
	// ****************************************
	localparam logic [13:0] MU_CLIP     = 14'h1FDE;
	localparam logic [14:0] MU_BIAS     = 15'h0021;
	localparam logic [15:0] MU_DEC_BIAS = 16'h0084;
	localparam logic [7:0]  A_XOR       = 8'h55;
	localparam int          GAIN_FRAC   = 14;
	localparam logic [15:0][15:0] GAIN_UP = {16'h4C10, 16'h4B31, 16'h4A55, 16'h497B, 16'h48A4, 16'h47CF,
		16'h46FD, 16'h462D, 16'h455F, 16'h4494, 16'h43CB, 16'h4304, 16'h4240, 16'h417E, 16'h40BE, 16'h4000};
	localparam logic [15:0][15:0] GAIN_DN = {16'h35D9, 16'h3679, 16'h371B, 16'h37BE, 16'h3863, 16'h390B,
		16'h39B4, 16'h3A5F, 16'h3B0C, 16'h3BBB, 16'h3C6C, 16'h3D1F, 16'h3DD4, 16'h3E8C, 16'h3F45, 16'h4000};
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic [15:0] sample;
	} ggt_sample_t;
	typedef struct packed {
		logic       valid;
		logic       b1_en;
		logic       b2_en;
		logic [7:0] b1;
		logic [7:0] b2;
	} ggt_link_t;
	typedef struct packed {
		logic       update;
		logic [7:0] current;
		logic [7:0] voltage;
	} ggt_meas_t;
endpackage

// ### hdl/ggt_regs.sv
/*
 * register bank with fine receive gain, link data format and line
 * threshold interrupt, plus the datapath these registers steer.
 * assumes an Avalon-MM master on clk_i and synchronous datapath inputs.
 */
module ggt_regs (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	// avalon-mm slave
	input  wire logic [7:0]        avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	// receive path line to link
	input  wire ggt_pkg::ggt_sample_t rx_line_i,
	output ggt_pkg::ggt_link_t     link_tx_o,
	// transmit path link to line
	input  wire ggt_pkg::ggt_link_t link_rx_i,
	output ggt_pkg::ggt_sample_t   line_tx_o,
	// line measurements
	input  wire ggt_pkg::ggt_meas_t meas_i,
	// interrupt
	output logic                   pwm_or_irq_pin_o
);
	// ****************************************
	// companding helpers
	// ****************************************
	function automatic logic [7:0] enc_mu(input logic [15:0] s);
		logic        sgn;
		logic [13:0] mag;
		logic [14:0] biased;
		logic [2:0]  seg;
		logic [3:0]  mant;
		sgn = s[15];
		mag = sgn ? ~s[15:2] : s[15:2];
		if (mag > ggt_pkg::MU_CLIP) begin
			mag = ggt_pkg::MU_CLIP;
		end
		biased = {1'b0, mag} + ggt_pkg::MU_BIAS;
		seg = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (biased[i + 5]) begin
				seg = 3'(i);
			end
		end
		mant = 4'(biased >> (seg + 3'h1));
		return ~{sgn, seg, mant};
	endfunction

	function automatic logic [15:0] dec_mu(input logic [7:0] c);
		logic [7:0]  u;
		logic [15:0] t;
		u = ~c;
		t = ({9'h000, u[3:0], 3'h0} + ggt_pkg::MU_DEC_BIAS) << u[6:4];
		return u[7] ? ggt_pkg::MU_DEC_BIAS - t : t - ggt_pkg::MU_DEC_BIAS;
	endfunction

	function automatic logic [7:0] enc_a(input logic [15:0] s);
		logic        sgn;
		logic [11:0] mag;
		logic [2:0]  seg;
		logic [3:0]  mant;
		sgn = s[15];
		mag = sgn ? ~s[14:3] : s[14:3];
		seg = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (mag[i + 4]) begin
				seg = 3'(i);
			end
		end
		mant = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
		return {~sgn, seg, mant} ^ ggt_pkg::A_XOR;
	endfunction

	function automatic logic [15:0] dec_a(input logic [7:0] c);
		logic [7:0]  a;
		logic [15:0] t;
		a = c ^ ggt_pkg::A_XOR;
		if (a[6:4] == 3'h0) begin
			t = {8'h00, a[3:0], 4'h8};
		end else begin
			t = {7'h00, 1'b1, a[3:0], 4'h8} << (a[6:4] - 3'h1);
		end
		return a[7] ? t : 16'(-t);
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [31:0]          rdata_reg, rdata_next;
	logic                 wait_reg, wait_next;
	logic [4:0]           gain_reg, gain_next;
	logic [3:0]           gci_reg, gci_next;
	logic [7:0]           thr_reg, thr_next;
	logic [2:0]           thr_ctl_reg, thr_ctl_next;
	logic [1:0]           ctl_reg, ctl_next;
	logic [2:0]           msk_reg, msk_next;
	logic [2:0]           sts_reg, sts_next;
	logic                 flag_reg, flag_next;
	logic                 cond_reg, cond_next;
	logic                 irq_reg, irq_next;
	ggt_pkg::ggt_sample_t gain_out_reg, gain_out_next;
	logic                 sat_reg, sat_next;
	ggt_pkg::ggt_link_t   tx_reg, tx_next;
	ggt_pkg::ggt_sample_t line_reg, line_next;

	logic       wr_go;
	logic [5:0] idx;
	logic [1:0] fmt;
	logic       b1_on;
	logic       b2_on;
	logic       slot_b2;

	assign idx     = avs_address_i[7:2];
	assign wr_go   = avs_write_i & ~wait_reg & avs_byteenable_i[0];
	assign fmt     = gci_reg[ggt_pkg::FMT_LSB +: 2];
	assign b1_on   = gci_reg[ggt_pkg::B1_EN_BIT];
	assign b2_on   = gci_reg[ggt_pkg::B2_EN_BIT];
	assign slot_b2 = ctl_reg[ggt_pkg::SLOT_SEL_BIT];

	// ****************************************
	// bus slave and configuration
	// ****************************************
	always_comb begin
		wait_next    = ~((avs_read_i | avs_write_i) & wait_reg);
		rdata_next   = rdata_reg;
		gain_next    = gain_reg;
		gci_next     = gci_reg;
		thr_next     = thr_reg;
		thr_ctl_next = thr_ctl_reg;
		ctl_next     = ctl_reg;
		msk_next     = msk_reg;
		if (avs_read_i & wait_reg) begin
			case (idx)
				ggt_pkg::IDX_RX_FINE_GAIN: rdata_next = {27'h0000000, gain_reg};
				ggt_pkg::IDX_GCI_FORMAT:   rdata_next = {28'h0000000, gci_reg};
				ggt_pkg::IDX_THR_VALUE:    rdata_next = {24'h000000, thr_reg};
				ggt_pkg::IDX_THR_IRQ_CTRL: rdata_next = {28'h0000000, flag_reg, thr_ctl_reg};
				ggt_pkg::IDX_IRQ_CONTROL:  rdata_next = {30'h00000000, ctl_reg};
				ggt_pkg::IDX_IRQ_STATUS:   rdata_next = {29'h00000000, sts_reg};
				ggt_pkg::IDX_IRQ_MASK:     rdata_next = {29'h00000000, msk_reg};
				default:                   rdata_next = 32'h00000000;
			endcase
		end
		if (wr_go) begin
			case (idx)
				ggt_pkg::IDX_RX_FINE_GAIN: gain_next    = avs_writedata_i[4:0];
				ggt_pkg::IDX_GCI_FORMAT:   gci_next     = avs_writedata_i[3:0];
				ggt_pkg::IDX_THR_VALUE:    thr_next     = avs_writedata_i[7:0];
				ggt_pkg::IDX_THR_IRQ_CTRL: thr_ctl_next = avs_writedata_i[2:0];
				ggt_pkg::IDX_IRQ_CONTROL:  ctl_next     = avs_writedata_i[1:0];
				ggt_pkg::IDX_IRQ_MASK:     msk_next     = avs_writedata_i[2:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_reg    <= 1'b1;
			rdata_reg   <= 32'h00000000;
			gain_reg    <= ggt_pkg::RST_BYTE[4:0];
			gci_reg     <= ggt_pkg::RST_BYTE[3:0];
			thr_reg     <= ggt_pkg::RST_BYTE;
			thr_ctl_reg <= ggt_pkg::RST_BYTE[2:0];
			ctl_reg     <= ggt_pkg::RST_BYTE[1:0];
			msk_reg     <= ggt_pkg::RST_BYTE[2:0];
		end else begin
			wait_reg    <= wait_next;
			rdata_reg   <= rdata_next;
			gain_reg    <= gain_next;
			gci_reg     <= gci_next;
			thr_reg     <= thr_next;
			thr_ctl_reg <= thr_ctl_next;
			ctl_reg     <= ctl_next;
			msk_reg     <= msk_next;
		end
	end

	// ****************************************
	// datapath: gain, link format, line return
	// ****************************************
	always_comb begin
		logic [15:0]        coef;
		logic signed [32:0] prod;
		logic signed [18:0] scaled;
		logic [7:0]         code;
		logic [7:0]         slot_byte;
		logic               slot_ok;
		code      = 8'h00;
		coef      = gain_reg[ggt_pkg::GAIN_DIR_BIT] ? ggt_pkg::GAIN_DN[gain_reg[3:0]]
		                                            : ggt_pkg::GAIN_UP[gain_reg[3:0]];
		prod      = $signed(rx_line_i.sample) * $signed({1'b0, coef});
		scaled    = prod[32:ggt_pkg::GAIN_FRAC];
		gain_out_next.valid = rx_line_i.valid;
		sat_next  = 1'b0;
		if (scaled > 19'sh07FFF) begin
			gain_out_next.sample = 16'h7FFF;
			sat_next = rx_line_i.valid;
		end else if (scaled < -19'sh08000) begin
			gain_out_next.sample = 16'h8000;
			sat_next = rx_line_i.valid;
		end else begin
			gain_out_next.sample = scaled[15:0];
		end
		// line to link
		case (fmt)
			ggt_pkg::FMT_ALAW:  code = enc_a(gain_out_reg.sample);
			ggt_pkg::FMT_MULAW: code = enc_mu(gain_out_reg.sample);
			default:            code = gain_out_reg.sample[15:8];
		endcase
		tx_next = '0;
		tx_next.valid = gain_out_reg.valid;
		if (gain_out_reg.valid) begin
			if (fmt == ggt_pkg::FMT_LIN16) begin
				tx_next.b1_en = b1_on;
				tx_next.b1    = b1_on ? gain_out_reg.sample[15:8] : 8'h00;
				tx_next.b2_en = b2_on;
				tx_next.b2    = b2_on ? gain_out_reg.sample[7:0] : 8'h00;
			end else begin
				tx_next.b1_en = b1_on & ~slot_b2;
				tx_next.b1    = (b1_on & ~slot_b2) ? code : 8'h00;
				tx_next.b2_en = b2_on & slot_b2;
				tx_next.b2    = (b2_on & slot_b2) ? code : 8'h00;
			end
			tx_next.valid = tx_next.b1_en | tx_next.b2_en;
		end
		// link to line
		slot_byte = slot_b2 ? link_rx_i.b2 : link_rx_i.b1;
		slot_ok   = slot_b2 ? (b2_on & link_rx_i.b2_en) : (b1_on & link_rx_i.b1_en);
		line_next = '0;
		if (fmt == ggt_pkg::FMT_LIN16) begin
			line_next.valid  = link_rx_i.valid & ((b1_on & link_rx_i.b1_en) | (b2_on & link_rx_i.b2_en));
			line_next.sample = {(b1_on & link_rx_i.b1_en) ? link_rx_i.b1 : 8'h00,
			                    (b2_on & link_rx_i.b2_en) ? link_rx_i.b2 : 8'h00};
		end else begin
			line_next.valid = link_rx_i.valid & slot_ok;
			case (fmt)
				ggt_pkg::FMT_ALAW:  line_next.sample = dec_a(slot_byte);
				ggt_pkg::FMT_MULAW: line_next.sample = dec_mu(slot_byte);
				default:            line_next.sample = {slot_byte, 8'h00};
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gain_out_reg <= '0;
			sat_reg      <= 1'b0;
			tx_reg       <= '0;
			line_reg     <= '0;
		end else begin
			gain_out_reg <= gain_out_next;
			sat_reg      <= sat_next;
			tx_reg       <= tx_next;
			line_reg     <= line_next;
		end
	end

	// ****************************************
	// threshold, status and interrupt
	// ****************************************
	always_comb begin
		logic [7:0] reading;
		logic [7:0] mag;
		logic       cond;
		logic       hit;
		logic [2:0] events;
		reading = thr_ctl_reg[ggt_pkg::THR_SEL_BIT] ? meas_i.voltage : meas_i.current;
		mag     = reading[7] ? 8'(-reading) : reading;
		cond    = thr_ctl_reg[ggt_pkg::THR_POL_BIT] ? (mag > thr_reg) : (mag < thr_reg);
		cond_next = meas_i.update ? cond : cond_reg;
		hit     = meas_i.update & cond & ~cond_reg;
		flag_next = flag_reg;
		if (wr_go && idx == ggt_pkg::IDX_THR_IRQ_CTRL && !avs_writedata_i[ggt_pkg::THR_FLAG_BIT]) begin
			flag_next = 1'b0;
		end
		if (hit) begin
			flag_next = 1'b1;
		end
		events = '0;
		events[ggt_pkg::EV_TX_BIT]  = tx_reg.valid;
		events[ggt_pkg::EV_RX_BIT]  = line_reg.valid;
		events[ggt_pkg::EV_SAT_BIT] = sat_reg;
		sts_next = sts_reg;
		if (wr_go && idx == ggt_pkg::IDX_IRQ_STATUS) begin
			sts_next = sts_reg & ~avs_writedata_i[2:0];
		end
		sts_next = sts_next | events;
		irq_next = ctl_reg[ggt_pkg::GLOBAL_IRQ_ENABLE_BIT]
			& ((flag_next & thr_ctl_reg[ggt_pkg::THR_MASK_BIT]) | (|(sts_next & msk_reg)));
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flag_reg <= 1'b0;
			cond_reg <= 1'b0;
			sts_reg  <= 3'h0;
			irq_reg  <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			cond_reg <= cond_next;
			sts_reg  <= sts_next;
			irq_reg  <= irq_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign avs_readdata_o    = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign link_tx_o         = tx_reg;
	assign line_tx_o         = line_reg;
	assign pwm_or_irq_pin_o  = irq_reg;
endmodule

// ### tb/ggt_host_model.sv
/*
 * link host model: drives host frames into the bank.
 * assumes frames are started just after a rising edge.
 */
module ggt_host_model (
	// clock
	input  wire logic          clk_i,
	// host frame out
	output ggt_pkg::ggt_link_t link_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial link_o = '0;
	// one-cycle frame, slots filled as told
	task automatic send(input logic e1, input logic e2, input logic [7:0] d1, input logic [7:0] d2);
		link_o <= '{1'b1, e1, e2, d1, d2};
		@(posedge clk_i);
		link_o <= '{1'b0, 1'b0, 1'b0, ~d1, ~d2};
	endtask
endmodule

// ### tb/ggt_regs_asserts.sv
/*
 * port checker for the register bank.
 * assumes it is bound to ggt_regs.
 */
module ggt_regs_asserts (
	input wire logic                 clk_i,
	input wire logic                 reset_n_i,
	input wire logic                 avs_read_i,
	input wire logic                 avs_write_i,
	input wire logic [31:0]          avs_readdata_o,
	input wire logic                 avs_waitrequest_o,
	input wire ggt_pkg::ggt_sample_t rx_line_i,
	input wire ggt_pkg::ggt_link_t   link_tx_o,
	input wire ggt_pkg::ggt_link_t   link_rx_i,
	input wire ggt_pkg::ggt_sample_t line_tx_o,
	input wire logic                 pwm_or_irq_pin_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_bus_answers: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus request not answered next cycle");
	a_bus_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	a_rsvd_zero: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_tx_after_rx: assert property (link_tx_o.valid |-> $past(rx_line_i.valid, 2))
		else $error("frame without sample two cycles before");
	a_tx_b1_off: assert property (link_tx_o.valid && !link_tx_o.b1_en |-> link_tx_o.b1 == 8'h00)
		else $error("data in disabled first slot");
	a_tx_b2_off: assert property (link_tx_o.valid && !link_tx_o.b2_en |-> link_tx_o.b2 == 8'h00)
		else $error("data in disabled second slot");
	a_tx_some_slot: assert property (link_tx_o.valid |-> link_tx_o.b1_en || link_tx_o.b2_en)
		else $error("frame with no slot enabled");
	a_rx_after_frame: assert property (line_tx_o.valid |-> $past(link_rx_i.valid && (link_rx_i.b1_en || link_rx_i.b2_en)))
		else $error("line sample without host frame");
	c_tx: cover property (link_tx_o.valid);
	c_rx: cover property (line_tx_o.valid);
	c_irq: cover property ($rose(pwm_or_irq_pin_o));
endmodule
bind ggt_regs ggt_regs_asserts chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.rx_line_i(rx_line_i), .link_tx_o(link_tx_o), .link_rx_i(link_rx_i), .line_tx_o(line_tx_o),
	.pwm_or_irq_pin_o(pwm_or_irq_pin_o));

// ### tb/gain_gci_threshold_regs_bench.sv
/*
 * self-checking bench for ggt_regs with the host model.
 * assumes package, design, checker and host model compiled first.
 */
module gain_gci_threshold_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
	// ****************************************
	// signals
	// ****************************************
	logic                 clk_i = 1'b0;
	logic                 reset_n_i = 1'b0;
	logic [7:0]           avs_address_i = 8'h00;
	logic                 avs_read_i = 1'b0;
	logic                 avs_write_i = 1'b0;
	logic [31:0]          avs_writedata_i = 32'h0;
	logic [31:0]          avs_readdata_o;
	logic                 avs_waitrequest_o;
	ggt_pkg::ggt_sample_t rx_line_i = '0;
	ggt_pkg::ggt_link_t   link_tx_o;
	ggt_pkg::ggt_link_t   link_rx_i;
	ggt_pkg::ggt_sample_t line_tx_o;
	ggt_pkg::ggt_meas_t   meas_i = '0;
	logic                 pwm_or_irq_pin_o;
	int                   num_errors = 0;
	int                   num_checks = 0;
	int                   cycles = 0;
	logic [31:0]          seed = 32'h227F;
	logic [15:0]          tx_q[$];
	logic [15:0]          rx_q[$];
	logic [15:0]          last_tx, prev_tx, s, e, g;
	logic [7:0]           q, h1, h2;
	logic [7:0]           msk[4] = '{8'h1F, 8'h0F, 8'hFF, 8'h07};
	logic [31:0]          thr[6] = '{32'h02500002, 32'h02D07F0A, 32'h02D07F02, 32'h05D01005, 32'h05D0900D,
		32'h0FD0900F};
	ggt_regs dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rx_line_i(rx_line_i),
		.link_tx_o(link_tx_o), .link_rx_i(link_rx_i), .line_tx_o(line_tx_o), .meas_i(meas_i),
		.pwm_or_irq_pin_o(pwm_or_irq_pin_o));
	ggt_host_model host_u (.clk_i(clk_i), .link_o(link_rx_i));
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	// ****************************************
	// helpers and monitors
	// ****************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [5:0] ix, input logic [7:0] d);
		int n;
		n = 0;
		avs_address_i <= {ix, 2'h0};
		avs_writedata_i <= {24'h0, d};
		avs_write_i <= w;
		avs_read_i <= !w;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 64);
		q = avs_readdata_o[7:0];
		if (n == 64) num_errors++;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic frame(input logic [15:0] smp, input logic ln);
		rx_line_i <= '{1'b1, smp};
		if (ln) host_u.send(1'b1, 1'b1, h1, h2);
		else @(posedge clk_i);
		rx_line_i.valid <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
		if (link_tx_o.valid === 1'b1) begin
			last_tx = {link_tx_o.b1, link_tx_o.b2};
			e = tx_q.size() ? tx_q.pop_front() : ~last_tx;
			`CHK(last_tx, e)
		end
		if (line_tx_o.valid === 1'b1) begin
			e = rx_q.size() ? rx_q.pop_front() : ~line_tx_o.sample;
			`CHK(line_tx_o.sample, e)
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 41; i < 46; i++) begin
			bus(1'b0, i[5:0], 8'h00);
			`CHK(q, 8'h00)
		end
		for (int i = 0; i < 4; i++) begin
			h1 = 8'(rnd());
			bus(1'b1, ggt_pkg::IDX_RX_FINE_GAIN + 6'(i), h1);
			bus(1'b0, ggt_pkg::IDX_RX_FINE_GAIN + 6'(i), 8'h00);
			`CHK(q, h1 & msk[i])
		end
		bus(1'b1, ggt_pkg::IDX_RX_FINE_GAIN, 8'h00);
		bus(1'b1, ggt_pkg::IDX_THR_IRQ_CTRL, 8'h00);
		for (int f = 0; f < 4; f++) begin
			for (int c = 0; c < 4; c++) begin
				bus(1'b1, ggt_pkg::IDX_GCI_FORMAT, {4'h0, f[1:0], c[1:0]});
				s = (f < 2) ? 16'h0000 : 16'(rnd());
				h1 = 8'(rnd());
				h2 = 8'(rnd());
				g = (f == 0) ? 16'hD500 : (f == 1) ? 16'hFF00 : {s[15:8], 8'h00};
				if (f < 3 && c[0]) tx_q.push_back(g);
				if (f == 2 && c == 1) rx_q.push_back({h1, 8'h00});
				if (f == 3 && c != 0) begin
					tx_q.push_back({c[0] ? s[15:8] : 8'h00, c[1] ? s[7:0] : 8'h00});
					rx_q.push_back({c[0] ? h1 : 8'h00, c[1] ? h2 : 8'h00});
				end
				frame(s, f == 3 || (f == 2 && c == 1));
				`CHK(tx_q.size() + rx_q.size(), 0)
			end
		end
		bus(1'b0, ggt_pkg::IDX_IRQ_STATUS, 8'h00);
		`CHK(q, 8'h03)
		bus(1'b1, ggt_pkg::IDX_IRQ_STATUS, 8'h03);
		bus(1'b0, ggt_pkg::IDX_IRQ_STATUS, 8'h00);
		`CHK(q, 8'h00)
		bus(1'b1, ggt_pkg::IDX_GCI_FORMAT, 8'h0F);
		for (int i = 0; i < 32; i++) begin
			bus(1'b1, ggt_pkg::IDX_RX_FINE_GAIN, 8'(i));
			tx_q.push_back(i[4] ? ggt_pkg::GAIN_DN[i[3:0]] : ggt_pkg::GAIN_UP[i[3:0]]);
			prev_tx = last_tx;
			frame(16'h4000, 1'b0);
			if (i[3:0] != 4'h0) `CHK(i[4] ? last_tx < prev_tx : last_tx > prev_tx, 1'b1)
		end
		bus(1'b1, ggt_pkg::IDX_THR_VALUE, 8'h40);
		bus(1'b1, ggt_pkg::IDX_IRQ_CONTROL, 8'h01);
		foreach (thr[i]) begin
			bus(1'b1, ggt_pkg::IDX_THR_IRQ_CTRL, thr[i][31:24]);
			meas_i <= '{1'b1, thr[i][23:16], thr[i][15:8]};
			@(posedge clk_i);
			meas_i.update <= 1'b0;
			repeat (3) @(posedge clk_i);
			bus(1'b0, ggt_pkg::IDX_THR_IRQ_CTRL, 8'h00);
			`CHK(q, thr[i][7:0])
			`CHK(pwm_or_irq_pin_o, thr[i][3] & thr[i][1])
		end
		bus(1'b1, ggt_pkg::IDX_IRQ_CONTROL, 8'h00);
		@(posedge clk_i);
		`CHK(pwm_or_irq_pin_o, 1'b0)
		tally_and_finish();
	end
endmodule
